// ### common/lbi_defs.svh
`ifndef LBI_DEFS_SVH
`define LBI_DEFS_SVH

// ----------------------------------------
// size_code encodings
// ----------------------------------------
`define LBI_SZ_LONG 2'h0
`define LBI_SZ_BYTE 2'h1
`define LBI_SZ_WORD 2'h2
`define LBI_SZ_LINE 2'h3

// ----------------------------------------
// port size encodings
// ----------------------------------------
`define LBI_PS_32 2'h0
`define LBI_PS_8 2'h1
`define LBI_PS_16 2'h2

// ----------------------------------------
// counts and reset values
// ----------------------------------------
`define LBI_NUM_CS 6
`define LBI_BOOT_WAITS 6'h3f
`define LBI_BOOT_SETTLE 2'h2
`define LBI_ACK_BLANK 2'h2
`define LBI_SYNC_LAT 7'h02

`endif

// ### common/lbi_pkg.sv
package lbi_pkg;

    // ----------------------------------------
    // bus sequencer states
    // ----------------------------------------
    typedef enum logic [3:0] {
        LBI_ST_IDLE = 4'h1,
        LBI_ST_ADDR = 4'h2,
        LBI_ST_DATA = 4'h4,
        LBI_ST_HOLD = 4'h8
    } lbi_state_e;

    // ----------------------------------------
    // per-select programming
    // ----------------------------------------
    typedef struct packed {
        logic valid;
        logic [15:0] base;
        logic [15:0] mask;
        logic [1:0] port;
        logic writes_only;
        logic auto_ack;
        logic [5:0] waits;
        logic burst_en;
    } lbi_cs_cfg_s;

    typedef struct packed {
        logic [1:0] port;
        logic auto_ack;
        logic writes_only;
    } lbi_strap_s;

    typedef struct packed {
        logic [31:0] addr;
        logic write;
        logic [1:0] size;
        logic burst_ok;
    } lbi_req_s;

    typedef struct packed {
        logic [31:0] data;
        logic [3:0] lanes;
    } lbi_rd_s;

    // ----------------------------------------
    // pin group driven to the bus
    // ----------------------------------------
    typedef struct packed {
        logic cycle_begin_pulse_n;
        logic direction_line;
        logic burst_flag_n;
        logic [1:0] size_code;
        logic [3:0] byte_lane_strobes_n;
        logic read_drive_enable_n;
        logic [31:0] ad_out;
        logic ad_oe;
    } lbi_bus_s;

endpackage : lbi_pkg

// ### verilog/lbi_select_match.sv
`timescale 1ns/100ps
`include "lbi_defs.svh"

module lbi_select_match #(
    parameter bit BOOT_SEL = 1'b0
) (
    // programming
    input wire lbi_pkg::lbi_cs_cfg_s cfg,
    input wire logic boot_global,
    // address
    input wire logic [31:0] addr,
    // result
    output logic hit
);
    import lbi_pkg::*;

    logic [15:0] cmp;

    // mask bits set mean "don't care"
    assign cmp = (addr[31:16] ^ cfg.base) & ~cfg.mask;
    // boot select answers everywhere until programmed
    assign hit = (cfg.valid && (cmp == 16'h0000)) || (BOOT_SEL && boot_global); // [RQ18] [RQ19]

endmodule : lbi_select_match

// ### verilog/lbi_bus_master.sv
`timescale 1ns/100ps
`include "lbi_defs.svh"

// Functional notes
// [RQ1] start pulse low exactly one clock per bus cycle, address and attributes valid
// [RQ2] outside party may latch the address with the start pulse
// [RQ3] direction high for reads, low for writes, for the whole cycle
// [RQ4] burst flag active while a 2 to 16 beat burst runs
// [RQ5] size code 00 long, 01 byte, 10 word, 11 line
// [RQ6] byte, word and long operands to 8, 16 and 32 bit ports
// [RQ7] misaligned operands split into natural pieces, each with its own size code
// [RQ8] aligned burst keeps size code at the whole transfer size every beat
// [RQ9] burst inhibited: first access whole size, later accesses port size
// [RQ10] per select, strobes on reads and writes, or on writes only
// [RQ11] only the byte lanes in use get a strobe
// [RQ12] read enable only on reads with a matching select
// [RQ13] outside party ends externally terminated cycles and sets wait states
// [RQ14] write data held one clock past select negation
// [RQ15] peripheral holds read data until acknowledge is seen
// [RQ16] termination by auto-acknowledge count or external acknowledge, per select
// [RQ17] full 32-bit address on the first clock of each cycle
// [RQ18] a select asserts only inside its base and mask space
// [RQ19] reset clears select programming; only boot select initialised, global
// [RQ20] after acknowledge drop select, strobes, read enable, then idle
// [RQ21] acknowledge sampled on rising edges; wait count starts at start pulse
module lbi_bus_master #(
    parameter int NUM_CS = `LBI_NUM_CS
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // boot straps
    input wire lbi_pkg::lbi_strap_s strap,
    // select programming
    input wire logic cfg_wr,
    input wire logic [2:0] cfg_idx,
    input wire lbi_pkg::lbi_cs_cfg_s cfg_data,
    // transfer requests
    input wire logic req_valid,
    input wire lbi_pkg::lbi_req_s req,
    output logic req_ready,
    output logic busy,
    output logic done,
    output logic miss,
    // data
    input wire logic [31:0] wr_data,
    output logic wr_take,
    output lbi_pkg::lbi_rd_s rd,
    output logic rd_valid,
    // bus pins
    input wire logic cycle_acknowledge_n,
    input wire logic [31:0] ad_in,
    output lbi_pkg::lbi_bus_s bus,
    output logic [NUM_CS-1:0] chip_select_lines_n
);
    import lbi_pkg::*;

    // ----------------------------------------
    // parameter check
    // ----------------------------------------
    generate
        if (NUM_CS < 1 || NUM_CS > 8) begin : g_bad
            $error("NUM_CS must be 1 to 8");
        end
    endgenerate

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        lbi_state_e fsm;
        lbi_cs_cfg_s [NUM_CS-1:0] select_control_regs;
        logic boot_global;
        logic boot_done;
        logic [1:0] boot_cnt;
        lbi_strap_s strap_s1;
        lbi_strap_s strap_s2;
        logic ack_s1;
        logic ack_s2;
        logic [31:0] ad_s1;
        logic [31:0] ad_s2;
        lbi_req_s req;
        lbi_cs_cfg_s cur;
        logic [31:0] addr;
        logic [4:0] rem;
        logic first;
        logic [4:0] beats_left;
        logic [4:0] beat_bytes;
        logic [6:0] wait_cnt;
        logic [1:0] blank;
        lbi_bus_s bus;
        logic [NUM_CS-1:0] cs_n;
        logic req_ready;
        lbi_rd_s rd;
        logic rd_valid;
        logic wr_take;
        logic done;
        logic miss;
        logic busy;
    } lbi_master_state_s;

    lbi_master_state_s st_ff;
    lbi_master_state_s nxt_st;
    logic [NUM_CS-1:0] hit;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [4:0] size_bytes(input logic [1:0] c);
        case (c)
            `LBI_SZ_BYTE: size_bytes = 5'h01;
            `LBI_SZ_WORD: size_bytes = 5'h02;
            `LBI_SZ_LINE: size_bytes = 5'h10;
            default: size_bytes = 5'h04;
        endcase
    endfunction : size_bytes

    function automatic logic [1:0] size_code_of(input logic [4:0] n);
        case (n)
            5'h01: size_code_of = `LBI_SZ_BYTE;
            5'h02: size_code_of = `LBI_SZ_WORD;
            default: size_code_of = `LBI_SZ_LONG;
        endcase
    endfunction : size_code_of

    function automatic logic [4:0] port_bytes(input logic [1:0] p);
        case (p)
            `LBI_PS_8: port_bytes = 5'h01;
            `LBI_PS_16: port_bytes = 5'h02;
            default: port_bytes = 5'h04;
        endcase
    endfunction : port_bytes

    // bit 3 is ad[31:24]; narrow ports sit on the upper lanes
    function automatic logic [3:0] lane_mask(input logic [1:0] p, input logic [1:0] o, input logic [4:0] n);
        logic [7:0] w;
        w = 8'hf0 >> n[2:0];
        case (p)
            `LBI_PS_32: lane_mask = w[3:0] >> o;
            `LBI_PS_16: lane_mask = w[3:0] >> o[0];
            default: lane_mask = 4'h8;
        endcase
    endfunction : lane_mask

    // ----------------------------------------
    // address decode, one matcher per select
    // ----------------------------------------
    generate
        for (genvar i = 0; i < NUM_CS; i++) begin : g_sel
            lbi_select_match #(
                .BOOT_SEL(i == 0)
            ) u_match (
                .cfg(st_ff.select_control_regs[i]),
                .boot_global(st_ff.boot_global),
                .addr(st_ff.addr),
                .hit(hit[i])
            );
        end
    endgenerate

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        logic [NUM_CS-1:0] sel_v;
        lbi_cs_cfg_s sel_cfg;
        logic [4:0] tb;
        logic [4:0] pb;
        logic [4:0] nat;
        logic aligned;
        logic term;
        logic [3:0] lanes;
        sel_v = '0;
        sel_cfg = '0;
        tb = size_bytes(st_ff.req.size);
        pb = 5'h04;
        nat = 5'h01;
        aligned = 1'b0;
        term = 1'b0;
        lanes = lane_mask(st_ff.cur.port, st_ff.addr[1:0], st_ff.beat_bytes);
        nxt_st = st_ff;

        // pins pass two flops before use
        nxt_st.ack_s1 = cycle_acknowledge_n; // [RQ21]
        nxt_st.ack_s2 = st_ff.ack_s1;
        nxt_st.ad_s1 = ad_in;
        nxt_st.ad_s2 = st_ff.ad_s1;
        nxt_st.strap_s1 = strap;
        nxt_st.strap_s2 = st_ff.strap_s1;

        nxt_st.rd_valid = 1'b0;
        nxt_st.wr_take = 1'b0;
        nxt_st.done = 1'b0;
        nxt_st.miss = 1'b0;
        nxt_st.bus.cycle_begin_pulse_n = 1'b1; // [RQ1]
        if (st_ff.blank != 2'h0) begin
            nxt_st.blank = st_ff.blank - 2'h1;
        end
        if (st_ff.wait_cnt != 7'h00) begin
            nxt_st.wait_cnt = st_ff.wait_cnt - 7'h01; // [RQ21]
        end
        if (st_ff.wr_take) begin
            nxt_st.bus.ad_out = wr_data;
        end

        // boot select takes the settled straps once after reset
        if (!st_ff.boot_done) begin
            nxt_st.boot_cnt = st_ff.boot_cnt + 2'h1;
            if (st_ff.boot_cnt == `LBI_BOOT_SETTLE) begin
                nxt_st.select_control_regs[0].port = st_ff.strap_s2.port; // [RQ19]
                nxt_st.select_control_regs[0].auto_ack = st_ff.strap_s2.auto_ack;
                nxt_st.select_control_regs[0].writes_only = st_ff.strap_s2.writes_only;
                nxt_st.select_control_regs[0].waits = `LBI_BOOT_WAITS;
                nxt_st.boot_global = 1'b1;
                nxt_st.boot_done = 1'b1;
                nxt_st.req_ready = 1'b1;
            end
        end

        // lowest index wins when selects overlap
        for (int i = NUM_CS - 1; i >= 0; i--) begin
            if (hit[i]) begin
                sel_v = '0;
                sel_v[i] = 1'b1;
                sel_cfg = st_ff.select_control_regs[i];
            end
        end

        case (st_ff.fsm)
            LBI_ST_IDLE: begin
                // programming only while no transfer is owned
                if (st_ff.req_ready && cfg_wr && (32'(cfg_idx) < NUM_CS)) begin
                    nxt_st.select_control_regs[cfg_idx] = cfg_data;
                    if (cfg_idx == 3'h0) begin
                        nxt_st.boot_global = 1'b0;
                    end
                end
                if (st_ff.req_ready && req_valid) begin
                    nxt_st.req = req;
                    nxt_st.addr = req.addr;
                    nxt_st.rem = size_bytes(req.size);
                    nxt_st.first = 1'b1;
                    nxt_st.req_ready = 1'b0;
                    nxt_st.busy = 1'b1;
                end else if (st_ff.rem != 5'h00) begin
                    if (sel_v == '0) begin
                        // no select claims the address: drop without a bus cycle
                        nxt_st.miss = 1'b1;
                        nxt_st.done = 1'b1;
                        nxt_st.rem = 5'h00;
                        nxt_st.busy = 1'b0;
                        nxt_st.req_ready = 1'b1;
                    end else begin
                        pb = port_bytes(sel_cfg.port); // [RQ6]
                        aligned = (st_ff.addr[3:0] & (tb[3:0] - 4'h1)) == 4'h0;
                        if (pb >= 5'h04 && st_ff.rem >= 5'h04 && st_ff.addr[1:0] == 2'h0) begin
                            nat = 5'h04;
                        end else if (pb >= 5'h02 && st_ff.rem >= 5'h02 && !st_ff.addr[0]) begin
                            nat = 5'h02;
                        end
                        if (st_ff.first && aligned && tb > pb && sel_cfg.burst_en && st_ff.req.burst_ok) begin
                            nxt_st.bus.burst_flag_n = 1'b0; // [RQ4]
                            nxt_st.bus.size_code = st_ff.req.size; // [RQ8] [RQ5]
                            nxt_st.beat_bytes = pb;
                            nxt_st.beats_left = (pb == 5'h04) ? tb >> 2 : (pb == 5'h02) ? tb >> 1 : tb;
                        end else begin
                            nxt_st.bus.burst_flag_n = 1'b1;
                            nxt_st.beat_bytes = nat; // [RQ7]
                            nxt_st.beats_left = 5'h01;
                            if (st_ff.first && aligned && tb > pb) begin
                                nxt_st.bus.size_code = st_ff.req.size; // [RQ9]
                            end else begin
                                nxt_st.bus.size_code = size_code_of(nat); // [RQ7] [RQ9]
                            end
                        end
                        nxt_st.cur = sel_cfg;
                        nxt_st.fsm = LBI_ST_ADDR;
                        nxt_st.bus.cycle_begin_pulse_n = 1'b0; // [RQ1]
                        nxt_st.bus.direction_line = !st_ff.req.write; // [RQ3]
                        nxt_st.cs_n = ~sel_v; // [RQ18]
                        nxt_st.bus.ad_out = st_ff.addr; // [RQ17]
                        nxt_st.bus.ad_oe = 1'b1;
                        nxt_st.wr_take = st_ff.req.write;
                        // reads wait out the pin synchroniser before sampling
                        nxt_st.wait_cnt = {1'b0, sel_cfg.waits} + (st_ff.req.write ? 7'h00 : `LBI_SYNC_LAT); // [RQ21]
                        nxt_st.first = 1'b0;
                    end
                end
            end
            LBI_ST_ADDR: begin
                nxt_st.fsm = LBI_ST_DATA;
                nxt_st.bus.ad_oe = st_ff.req.write;
                if (st_ff.req.write || !st_ff.cur.writes_only) begin
                    nxt_st.bus.byte_lane_strobes_n = ~lanes; // [RQ10] [RQ11]
                end
                nxt_st.bus.read_drive_enable_n = st_ff.req.write; // [RQ12]
            end
            LBI_ST_DATA: begin
                if (st_ff.cur.auto_ack) begin
                    term = st_ff.wait_cnt == 7'h00; // [RQ16]
                end else begin
                    term = !st_ff.ack_s2 && st_ff.blank == 2'h0; // [RQ16] [RQ13]
                end
                if (term) begin
                    // a held acknowledge must not end the following beat too
                    if (!st_ff.cur.auto_ack) begin
                        nxt_st.blank = `LBI_ACK_BLANK;
                    end
                    if (!st_ff.req.write) begin
                        nxt_st.rd.data = st_ff.ad_s2; // [RQ15]
                        nxt_st.rd.lanes = lanes;
                        nxt_st.rd_valid = 1'b1;
                    end
                    nxt_st.addr = st_ff.addr + 32'(st_ff.beat_bytes);
                    nxt_st.rem = st_ff.rem - st_ff.beat_bytes;
                    if (st_ff.beats_left > 5'h01) begin
                        nxt_st.beats_left = st_ff.beats_left - 5'h01;
                        nxt_st.wait_cnt = {1'b0, st_ff.cur.waits} + 7'h01
                            + (st_ff.req.write ? 7'h00 : `LBI_SYNC_LAT);
                        nxt_st.wr_take = st_ff.req.write;
                    end else begin
                        nxt_st.fsm = LBI_ST_HOLD;
                        nxt_st.cs_n = '1; // [RQ20]
                        nxt_st.bus.byte_lane_strobes_n = 4'hf; // [RQ20]
                        nxt_st.bus.read_drive_enable_n = 1'b1; // [RQ20]
                        nxt_st.bus.burst_flag_n = 1'b1; // [RQ4]
                    end
                end
            end
            LBI_ST_HOLD: begin
                // write data stayed on the bus through this clock
                nxt_st.fsm = LBI_ST_IDLE; // [RQ20]
                nxt_st.bus.ad_oe = 1'b0; // [RQ14]
                if (st_ff.rem == 5'h00) begin
                    nxt_st.done = 1'b1;
                    nxt_st.busy = 1'b0;
                    nxt_st.req_ready = 1'b1;
                end
            end
            default: begin
                nxt_st.fsm = LBI_ST_IDLE;
            end
        endcase
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            st_ff <= '0; // [RQ19]
            st_ff.fsm <= LBI_ST_IDLE;
            st_ff.ack_s1 <= 1'b1;
            st_ff.ack_s2 <= 1'b1;
            st_ff.cs_n <= '1;
            st_ff.bus.cycle_begin_pulse_n <= 1'b1;
            st_ff.bus.direction_line <= 1'b1;
            st_ff.bus.burst_flag_n <= 1'b1;
            st_ff.bus.byte_lane_strobes_n <= 4'hf;
            st_ff.bus.read_drive_enable_n <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign bus = st_ff.bus;
    assign chip_select_lines_n = st_ff.cs_n;
    assign req_ready = st_ff.req_ready;
    assign busy = st_ff.busy;
    assign done = st_ff.done;
    assign miss = st_ff.miss;
    assign wr_take = st_ff.wr_take;
    assign rd = st_ff.rd;
    assign rd_valid = st_ff.rd_valid;

endmodule : lbi_bus_master

// ### testbench/lbi_chk_assertions.sv
`timescale 1ns/100ps
`include "lbi_defs.svh"

module lbi_chk_assertions #(
    parameter int NUM_CS = 6
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // handshake
    input wire logic done,
    input wire logic miss,
    // bus pins
    input wire lbi_pkg::lbi_bus_s bus,
    input wire logic [NUM_CS-1:0] chip_select_lines_n
);
    import lbi_pkg::*;
    logic idle_cs;
    logic [8:0] low_cnt_ff;
    logic [8:0] nxt_low_cnt;
    assign idle_cs = &chip_select_lines_n;
    // long select-low stretch means a lost termination
    always_comb begin
        nxt_low_cnt = idle_cs ? 9'h000 : low_cnt_ff + 9'h001;
    end
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            low_cnt_ff <= 9'h000;
        end else begin
            low_cnt_ff <= nxt_low_cnt;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    chk_begin_one_clk: assert property ($fell(bus.cycle_begin_pulse_n) |=> bus.cycle_begin_pulse_n)
        else $error("start pulse wider than one clock");
    chk_addr_phase: assert property (!bus.cycle_begin_pulse_n |-> bus.ad_oe && !idle_cs)
        else $error("address phase without select or drive");
    chk_dir_steady: assert property (!idle_cs && !$past(idle_cs) |-> $stable(bus.direction_line))
        else $error("direction changed inside a cycle");
    chk_read_enable: assert property (!bus.read_drive_enable_n |-> bus.direction_line && !idle_cs)
        else $error("read enable outside a selected read");
    chk_strobe_phase: assert property (bus.byte_lane_strobes_n != 4'hf |-> !idle_cs && bus.cycle_begin_pulse_n)
        else $error("strobe outside the data phase");
    chk_write_hold: assert property ($rose(idle_cs) && !$past(bus.direction_line) |-> bus.ad_oe)
        else $error("write data released with the select");
    chk_idle_gap: assert property ($rose(idle_cs) |-> bus.cycle_begin_pulse_n [*2])
        else $error("start pulse too soon after a cycle");
    chk_burst_size: assert property (!bus.burst_flag_n && !bus.cycle_begin_pulse_n |-> bus.size_code != `LBI_SZ_BYTE)
        else $error("burst flagged on a byte transfer");
    chk_miss_quiet: assert property (miss |-> done && idle_cs && bus.cycle_begin_pulse_n)
        else $error("unmatched address drove the bus");
    chk_term_bound: assert property (low_cnt_ff <= 9'h12c)
        else $error("select held without termination");
    chk_reset_quiet: assert property ($rose(reset_n) |-> idle_cs && bus.cycle_begin_pulse_n && !bus.ad_oe)
        else $error("bus active after reset");
    cover property (!bus.burst_flag_n);
    cover property (miss);
    cover property ($rose(idle_cs) && !$past(bus.direction_line));
endmodule : lbi_chk_assertions

bind lbi_bus_master lbi_chk_assertions #(.NUM_CS(NUM_CS)) chk_u (.clk_sys(clk_sys), .reset_n(reset_n),
    .done(done), .miss(miss), .bus(bus), .chip_select_lines_n(chip_select_lines_n));

// ### testbench/lbi_periph_model.sv
`timescale 1ns/100ps

module lbi_periph_model #(
    parameter int NUM_CS = 6,
    parameter int WAITS = 3
) (
    // clock
    input wire logic clk_sys,
    // bus pins
    input wire lbi_pkg::lbi_bus_s bus,
    input wire logic [NUM_CS-1:0] chip_select_lines_n,
    input wire logic [NUM_CS-1:0] ext_mask,
    output logic cycle_acknowledge_n,
    output logic [31:0] ad_in,
    // observed write word
    output logic [31:0] wr_last
);
    logic [31:0] addr_ff;
    int cnt_ff;
    logic sel;
    logic ext;
    assign sel = ~&chip_select_lines_n;
    assign ext = |(~chip_select_lines_n & ext_mask);
    // released bus shows the inverse so stale data never passes
    assign ad_in = sel ? (addr_ff ^ 32'h5a5a_5a5a) : ~(addr_ff ^ 32'h5a5a_5a5a);
    initial begin
        addr_ff = 32'h0;
        cnt_ff = 0;
        cycle_acknowledge_n = 1'b1;
        wr_last = 32'h0;
    end
    always @(posedge clk_sys) begin
        if (!bus.cycle_begin_pulse_n) begin
            addr_ff <= bus.ad_out;
        end
        if (!bus.direction_line && bus.ad_oe && bus.byte_lane_strobes_n != 4'hf) begin
            wr_last <= bus.ad_out;
        end
        cycle_acknowledge_n <= 1'b1;
        // gap after each ack outlasts the master's ack blanking
        if (!ext || !bus.cycle_begin_pulse_n) begin
            cnt_ff <= 0;
        end else if (cnt_ff == WAITS + 4) begin
            cycle_acknowledge_n <= 1'b0;
            cnt_ff <= 0;
        end else begin
            cnt_ff <= cnt_ff + 1;
        end
    end
endmodule : lbi_periph_model

// ### testbench/testbench.sv
`timescale 1ns/100ps
`include "lbi_defs.svh"

module testbench;
    import lbi_pkg::*;
    localparam logic [31:0] WR_PAT = 32'hc3a5_19e7;
    localparam lbi_cs_cfg_s CS0 = '{1'b1, 16'h0000, 16'h0fff, `LBI_PS_32, 1'b0, 1'b1, 6'h02, 1'b1};
    localparam lbi_cs_cfg_s CS1 = '{1'b1, 16'h4000, 16'h0000, `LBI_PS_8, 1'b1, 1'b0, 6'h00, 1'b1};
    logic clk_sys, reset_n, cfg_wr, req_valid, req_ready, busy, done, miss, wr_take, rd_valid, ack_n;
    logic [2:0] cfg_idx;
    logic [31:0] wr_data, ad_in, wr_last;
    logic [5:0] cs_n;
    lbi_strap_s strap;
    lbi_cs_cfg_s cfg_data;
    lbi_req_s req;
    lbi_rd_s rd, last_rd;
    lbi_bus_s bus;
    logic [1:0] sz_q[$];
    int n_start, n_take, n_rdv, cyc, error_cnt, checks_done;
    logic saw_miss, strobe_rd;

    lbi_bus_master #(.NUM_CS(6)) dut_u (.clk_sys(clk_sys), .reset_n(reset_n), .strap(strap), .cfg_wr(cfg_wr),
        .cfg_idx(cfg_idx), .cfg_data(cfg_data), .req_valid(req_valid), .req(req), .req_ready(req_ready),
        .busy(busy), .done(done), .miss(miss), .wr_data(wr_data), .wr_take(wr_take), .rd(rd),
        .rd_valid(rd_valid), .cycle_acknowledge_n(ack_n), .ad_in(ad_in), .bus(bus),
        .chip_select_lines_n(cs_n));
    lbi_periph_model #(.NUM_CS(6), .WAITS(3)) per_u (.clk_sys(clk_sys), .bus(bus), .chip_select_lines_n(cs_n),
        .ext_mask(6'h02), .cycle_acknowledge_n(ack_n), .ad_in(ad_in), .wr_last(wr_last));

    always #20 clk_sys = ~clk_sys;

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : close_out

    task automatic cfg_put(input logic [2:0] i, input lbi_cs_cfg_s c);
        while (req_ready !== 1'b1) @(posedge clk_sys) #1;
        cfg_idx = i;
        cfg_data = c;
        cfg_wr = 1'b1;
        @(posedge clk_sys) #1;
        cfg_wr = 1'b0;
        @(posedge clk_sys) #1;
    endtask : cfg_put

    task automatic xfer(input logic [31:0] a, input logic w, input logic [1:0] s, input logic bok);
        n_start = 0;
        n_take = 0;
        n_rdv = 0;
        saw_miss = 1'b0;
        strobe_rd = 1'b0;
        sz_q.delete();
        while (req_ready !== 1'b1) @(posedge clk_sys) #1;
        req = '{a, w, s, bok};
        req_valid = 1'b1;
        @(posedge clk_sys) #1;
        req_valid = 1'b0;
        chk("busy", 1, {31'h0, busy});
        while (done !== 1'b1) @(posedge clk_sys) #1;
        @(posedge clk_sys) #1;
    endtask : xfer

    // ----------------------------------------
    // bus monitor and hang guard
    // ----------------------------------------
    always @(posedge clk_sys) begin
        cyc++;
        if (bus.cycle_begin_pulse_n === 1'b0) begin
            n_start++;
            sz_q.push_back(bus.size_code);
        end
        if (wr_take === 1'b1) n_take++;
        if (rd_valid === 1'b1) begin
            n_rdv++;
            last_rd = rd;
        end
        if (miss === 1'b1) saw_miss = 1'b1;
        if (bus.direction_line === 1'b1 && bus.byte_lane_strobes_n !== 4'hf) strobe_rd = 1'b1;
        if (cyc == 20000) begin
            error_cnt++;
            close_out();
        end
    end

    initial begin
        clk_sys = 1'b0;
        reset_n = 1'b0;
        strap = '{`LBI_PS_32, 1'b1, 1'b0};
        {cfg_wr, cfg_idx, cfg_data, req_valid, req} = '0;
        wr_data = WR_PAT;
        repeat (10) @(posedge clk_sys);
        #1 reset_n = 1'b1;
        xfer(32'h0000_0040, 1'b0, `LBI_SZ_LONG, 1'b1);
        chk("boot data", 32'h5a5a_5a1a, last_rd.data);
        chk("boot lanes", 32'hf, {28'h0, last_rd.lanes});
        chk("boot starts", 1, n_start);
        $display("test boot_read done");
        cfg_put(3'h0, CS0);
        cfg_put(3'h1, CS1);
        xfer(32'h0000_0100, 1'b1, `LBI_SZ_LONG, 1'b1);
        chk("write word", WR_PAT, wr_last);
        chk("write takes", 1, n_take);
        $display("test write_long done");
        for (int k = 0; k < 4; k++) begin
            xfer(32'h0000_0200, 1'b0, k[1:0], 1'b1);
            chk("size code", k, {30'h0, sz_q[0]});
            chk("read beats", (k == 3) ? 4 : 1, n_rdv);
            chk("one start", 1, n_start);
            chk("read strobes", 1, {31'h0, strobe_rd});
        end
        $display("test size_codes done");
        xfer(32'h4000_0000, 1'b1, `LBI_SZ_LONG, 1'b1);
        chk("burst starts", 1, n_start);
        chk("burst takes", 4, n_take);
        chk("burst size", `LBI_SZ_LONG, {30'h0, sz_q[0]});
        xfer(32'h4000_0000, 1'b1, `LBI_SZ_LONG, 1'b0);
        chk("split starts", 4, n_start);
        for (int j = 0; j < 4; j++) begin
            chk("split size", (j == 0) ? `LBI_SZ_LONG : `LBI_SZ_BYTE, {30'h0, sz_q[j]});
        end
        $display("test narrow_port done");
        xfer(32'h0000_0301, 1'b0, `LBI_SZ_LONG, 1'b1);
        chk("misaligned starts", 3, n_start);
        chk("piece 0", `LBI_SZ_BYTE, {30'h0, sz_q[0]});
        chk("piece 1", `LBI_SZ_WORD, {30'h0, sz_q[1]});
        chk("piece 2", `LBI_SZ_BYTE, {30'h0, sz_q[2]});
        chk("misaligned beats", 3, n_rdv);
        $display("test misaligned done");
        xfer(32'h4000_0010, 1'b0, `LBI_SZ_BYTE, 1'b1);
        chk("writes only strobes", 0, {31'h0, strobe_rd});
        chk("ext ack beats", 1, n_rdv);
        chk("ext ack data", 32'h1a5a_5a4a, last_rd.data);
        xfer(32'h9000_0000, 1'b0, `LBI_SZ_LONG, 1'b1);
        chk("miss flag", 1, {31'h0, saw_miss});
        chk("miss starts", 0, n_start);
        $display("test select_decode done");
        close_out();
    end
endmodule : testbench
